// >>> rtl/angle_counter_consts.svh
/*
 constants of the angle counter: widths, reset values and timing counts.
 assumes nothing; definitions only, included by bare name.
*/
`ifndef ANGLE_COUNTER_CONSTS_SVH
`define ANGLE_COUNTER_CONSTS_SVH

// field widths
`define TICKS_W        10
`define MISS_W         8
`define RATE_W         15
`define PRESC_W        6
`define ANGLE_W        24
`define PERIOD_W       22

// clock and microcycle timing
`define SYS_CLK_MHZ    200
`define MICROCYCLE_NS  10
`define MICRO_DIV      ((`MICROCYCLE_NS * `SYS_CLK_MHZ) / 1000)
`define MICRO_CNT_W    4

// reset values
`define TICKS_RST      10'h000
`define MISS_RST       8'h00
`define ANGLE_RST      24'h000000

`endif

// >>> rtl/angle_counter_pkg.sv
/*
 types of the angle counter: tooth program word and counter mode.
 assumes angle_counter_consts.svh is on the include path.
*/
`include "angle_counter_consts.svh"

package angle_counter_pkg;

   // one software write of the tooth program register
   typedef struct packed {
      logic [`TICKS_W-1:0] ticks;
      logic [`MISS_W-1:0]  missing_tooth_count;
      logic                last;
      logic                insert_tooth_bit;
   } tooth_program_t;

   // angle counter operating modes
   typedef enum logic [1:0] {
      mode_halt,
      mode_high_rate,
      mode_normal
   } counter_mode_t;

   // status seen by software
   typedef struct packed {
      counter_mode_t       mode;
      logic [`TICKS_W-1:0] ticks_left;
      logic [`MISS_W-1:0]  missing_tooth_count;
      logic                last;
   } counter_status_t;

endpackage

// >>> rtl/angle_counter_tooth_logic.sv
/*
 angle counter tooth logic: tracks engine angle from tooth events, with
 halt, high rate and normal modes, a two-deep tooth program write buffer
 and a microcycle/tick time base.
 assumes tooth_in is an asynchronous pin, software writes are one-cycle
 pulses on sys_clk, and rate/prescaler are static between teeth.
*/
`timescale 1ns/1ps
`include "angle_counter_consts.svh"

// Notes on behaviour
// - second write after insert write is never lost
// - insert bit generates a dummy tooth event
// - early tooth with missing count returns high rate
// - no halt while missing count above zero
// - clear missing and last only on switch
// - halt follows newly written missing count
// - never halt holding a non-zero missing count
module angle_counter_tooth_logic
   import angle_counter_pkg::*;
(
   // clock and reset
   input  wire logic                  sys_clk,
   input  wire logic                  resetn,
   // tooth wheel pin
   input  wire logic                  tooth_in,
   // tooth program register write
   input  wire logic                  tpr_wr,
   input  wire tooth_program_t        tpr_wdata,
   // time base configuration
   input  wire logic [`RATE_W-1:0]    tick_rate_value,
   input  wire logic [`PRESC_W-1:0]   time_base_prescaler,
   // status
   output counter_status_t            status,
   output logic [`ANGLE_W-1:0]        angle_count,
   output logic                       tooth_event,
   output logic                       tick_pulse,
   output logic                       microcycle,
   output logic                       tpr_buffer_full
);

   // tick period in microcycles, never below one
   function automatic logic [`PERIOD_W-1:0] tick_period(
      input logic [`RATE_W-1:0]  rate,
      input logic [`PRESC_W-1:0] presc);
      logic [`PERIOD_W-1:0] p;
      p = `PERIOD_W'(rate) * (`PERIOD_W'(presc) + `PERIOD_W'(1));
      if (p == '0) begin
         p = `PERIOD_W'(1);
      end
      return p;
   endfunction

   localparam logic [`MICRO_CNT_W-1:0] micro_last =
      `MICRO_CNT_W'(`MICRO_DIV - 1);

   // time base and pin state
   logic                   tooth_meta;
   logic                   tooth_sync;
   logic                   tooth_prev;
   logic                   tooth_pend;
   logic [`MICRO_CNT_W-1:0] micro_cnt;
   logic [`PERIOD_W-1:0]   tick_cnt;
   logic                   next_tooth_pend;
   logic [`MICRO_CNT_W-1:0] next_micro_cnt;
   logic [`PERIOD_W-1:0]   next_tick_cnt;
   logic                   micro_now;
   logic                   tick_now;

   // write buffer state
   tooth_program_t         slot0;
   tooth_program_t         slot1;
   logic                   slot0_valid;
   logic                   slot1_valid;
   tooth_program_t         next_slot0;
   tooth_program_t         next_slot1;
   logic                   next_slot0_valid;
   logic                   next_slot1_valid;
   logic                   apply;

   // counter state
   counter_mode_t          mode;
   logic [`TICKS_W-1:0]    tooth_ticks;
   logic [`TICKS_W-1:0]    ticks_left;
   logic [`MISS_W-1:0]     missing;
   logic                   last;
   logic [`ANGLE_W-1:0]    angle;
   counter_mode_t          next_mode;
   logic [`TICKS_W-1:0]    next_tooth_ticks;
   logic [`TICKS_W-1:0]    next_ticks_left;
   logic [`MISS_W-1:0]     next_missing;
   logic                   next_last;
   logic [`ANGLE_W-1:0]    next_angle;
   logic                   next_tooth_event;
   logic                   next_tick_pulse;
   logic                   tooth_any;

   assign micro_now = (micro_cnt == micro_last);
   assign tick_now  = micro_now && ((mode == mode_high_rate) ||
      (tick_cnt >= tick_period(tick_rate_value, time_base_prescaler)
       - `PERIOD_W'(1)));
   assign apply     = micro_now && slot0_valid;

   // time base next state; a tooth edge is held until its microcycle
   always_comb begin
      next_tooth_pend = (tooth_sync & ~tooth_prev) |
                        (tooth_pend & ~micro_now);   // edge wins over clear
      next_micro_cnt  = micro_now ? '0 : micro_cnt + `MICRO_CNT_W'(1);
      next_tick_cnt   = tick_cnt;
      if (micro_now) begin
         next_tick_cnt = tick_now ? '0 : tick_cnt + `PERIOD_W'(1);
      end
   end

   // write buffer: two slots so a write right after an insert write
   // survives a tooth in the same microcycle; a third overwrites slot1
   always_comb begin
      next_slot0       = slot0;
      next_slot1       = slot1;
      next_slot0_valid = slot0_valid;
      next_slot1_valid = slot1_valid;
      if (micro_now) begin
         next_slot0       = slot1;
         next_slot0_valid = slot1_valid;
         next_slot1_valid = 1'b0;
      end
      if (tpr_wr) begin
         if (!next_slot0_valid) begin
            next_slot0       = tpr_wdata;
            next_slot0_valid = 1'b1;
         end else begin
            next_slot1       = tpr_wdata;
            next_slot1_valid = 1'b1;
         end
      end
   end

   // mode and counts, evaluated only on a microcycle
   always_comb begin
      next_mode        = mode;
      next_tooth_ticks = tooth_ticks;
      next_ticks_left  = ticks_left;
      next_missing     = missing;
      next_last        = last;
      next_angle       = angle;
      next_tooth_event = 1'b0;
      next_tick_pulse  = tick_now;
      tooth_any        = 1'b0;
      if (micro_now) begin
         // written fields take effect before this microcycle's decision
         if (apply) begin
            next_tooth_ticks = slot0.ticks;
            next_missing     = slot0.missing_tooth_count;
            next_last        = slot0.last;
         end
         tooth_any = tooth_pend |
                     (apply & slot0.insert_tooth_bit);
         next_tooth_event = tooth_any;
         unique case (mode)
            mode_halt: begin
               if (tooth_any) begin
                  next_mode       = mode_normal;
                  next_ticks_left = next_tooth_ticks;
               end
            end
            mode_high_rate: begin
               if (tooth_any) begin
                  next_ticks_left = next_tooth_ticks;
               end else if (ticks_left != '0) begin
                  next_ticks_left = ticks_left - `TICKS_W'(1);
                  next_angle      = angle + `ANGLE_W'(1);
               end else begin
                  next_mode = mode_normal;
               end
            end
            mode_normal: begin
               if (tooth_any) begin
                  if (ticks_left != '0 && next_missing != '0) begin
                     next_mode    = mode_high_rate;
                     next_missing = '0;
                     next_last    = 1'b0;
                  end
                  next_ticks_left = next_tooth_ticks;
               end else if (tick_now) begin
                  if (ticks_left != '0) begin
                     next_ticks_left = ticks_left - `TICKS_W'(1);
                     next_angle      = angle + `ANGLE_W'(1);
                  end else if (next_missing != '0) begin
                     // missing tooth: count down, stay in normal
                     next_missing    = next_missing - `MISS_W'(1);
                     next_ticks_left = next_tooth_ticks;
                  end else begin
                     next_mode = mode_halt;
                  end
               end
            end
         endcase
      end
   end

   // registers of all groups
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         tooth_meta      <= 1'b0;
         tooth_sync      <= 1'b0;
         tooth_prev      <= 1'b0;
         tooth_pend      <= 1'b0;
         micro_cnt       <= '0;
         tick_cnt        <= '0;
         slot0           <= '0;
         slot1           <= '0;
         slot0_valid     <= 1'b0;
         slot1_valid     <= 1'b0;
         mode            <= mode_halt;
         tooth_ticks     <= `TICKS_RST;
         ticks_left      <= `TICKS_RST;
         missing         <= `MISS_RST;
         last            <= 1'b0;
         angle           <= `ANGLE_RST;
         status          <= '0;
         angle_count     <= `ANGLE_RST;
         tooth_event     <= 1'b0;
         tick_pulse      <= 1'b0;
         microcycle      <= 1'b0;
         tpr_buffer_full <= 1'b0;
      end else begin
         tooth_meta      <= tooth_in;
         tooth_sync      <= tooth_meta;
         tooth_prev      <= tooth_sync;
         tooth_pend      <= next_tooth_pend;
         micro_cnt       <= next_micro_cnt;
         tick_cnt        <= next_tick_cnt;
         slot0           <= next_slot0;
         slot1           <= next_slot1;
         slot0_valid     <= next_slot0_valid;
         slot1_valid     <= next_slot1_valid;
         mode            <= next_mode;
         tooth_ticks     <= next_tooth_ticks;
         ticks_left      <= next_ticks_left;
         missing         <= next_missing;
         last            <= next_last;
         angle           <= next_angle;
         status          <= '{next_mode, next_ticks_left, next_missing,
                              next_last};
         angle_count     <= next_angle;
         tooth_event     <= next_tooth_event;
         tick_pulse      <= next_tick_pulse;
         microcycle      <= micro_now;
         tpr_buffer_full <= next_slot1_valid;
      end
   end

endmodule

// >>> tb/angle_counter_tooth_logic_sva.sv
/*
 checker of the angle counter mode, tooth and microcycle behaviour.
 assumes it is bound into angle_counter_tooth_logic; one clock domain.
*/
`timescale 1ns/1ps
module angle_counter_tooth_logic_sva
   import angle_counter_pkg::*;
(
   // clock, reset and write side
   input wire logic            sys_clk,
   input wire logic            resetn,
   input wire logic            tpr_wr,
   input wire tooth_program_t  tpr_wdata,
   // watched outputs
   input wire counter_status_t status,
   input wire logic            tooth_event,
   input wire logic            microcycle,
   input wire logic            tick_pulse,
   input wire logic            tpr_buffer_full
);
   logic [2:0] wr_hist;
   logic       quiet;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // writes in flight may legally steer the decision, so skip them
   always_comb quiet = (wr_hist == 3'h0);
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn)
         wr_hist <= 3'h0;
      else
         wr_hist <= {wr_hist[1:0], tpr_wr | tpr_buffer_full};
   end
   a_halt_entry_clear: assert property (
      status.mode == mode_halt && $past(status.mode) != mode_halt
      |-> status.missing_tooth_count == 8'h00) else $error("halt early");
   a_no_halt_missing: assert property (
      status.mode == mode_normal && status.missing_tooth_count != 8'h00
      && quiet && !tpr_wr |=> status.mode != mode_halt)
      else $error("halt with missing");
   a_early_high_rate: assert property (
      tooth_event && quiet && $past(status.mode) == mode_normal
      && $past(status.missing_tooth_count) != 8'h00
      && $past(status.ticks_left) != 10'h000
      |-> status.mode == mode_high_rate) else $error("no high rate");
   a_clear_on_switch: assert property (
      $past(status.mode) == mode_normal && $past(status.last)
      && !status.last && quiet |-> status.mode != mode_normal)
      else $error("cleared in normal");
   a_miss_single_step: assert property (
      $past(status.mode) == mode_normal && status.mode == mode_normal
      && quiet && $changed(status.missing_tooth_count)
      |-> status.missing_tooth_count
          == $past(status.missing_tooth_count) - 8'h01)
      else $error("bad missing step");
   a_insert_dummy_tooth: assert property (
      tpr_wr && tpr_wdata.insert_tooth_bit && !tpr_buffer_full
      |-> ##[1:8] tooth_event) else $error("no dummy tooth");
   a_halt_tooth_wake: assert property (
      tooth_event && quiet && $past(status.mode) == mode_halt
      |-> status.mode == mode_normal) else $error("no wake");
   a_micro_period: assert property (
      microcycle |=> !microcycle ##1 microcycle) else $error("microcycle");
   a_event_once: assert property (
      tooth_event |=> !tooth_event) else $error("double tooth");
   a_tick_on_micro: assert property (
      tick_pulse |-> microcycle) else $error("tick off microcycle");
   a_high_rate_tick: assert property (
      microcycle && $past(status.mode) == mode_high_rate |-> tick_pulse)
      else $error("no high rate tick");
endmodule

// >>> tb/tooth_wheel_model.sv
/*
 tooth wheel sensor: one clean tooth pulse per request.
 assumes fire is a one-cycle request on sys_clk.
*/
`timescale 1ns/1ps
module tooth_wheel_model (
   // clock and request
   input  wire logic sys_clk,
   input  wire logic fire,
   // sensor pin
   output logic      tooth_in
);
   logic [2:0] width = 3'h0;
   // held six clocks so the pin synchroniser cannot miss it
   always @(posedge sys_clk) begin
      if (fire)
         width <= 3'h6;
      else if (width != 3'h0)
         width <= width - 3'h1;
   end
   assign tooth_in = (width != 3'h0);
endmodule

// >>> tb/angle_counter_tooth_logic_bench.sv
/*
 self-checking bench of the angle counter tooth logic.
 assumes the sensor model and the bound checker are compiled first.
*/
`timescale 1ns/1ps
`include "angle_counter_consts.svh"
module angle_counter_tooth_logic_bench;
   import angle_counter_pkg::*;
   logic                sys_clk;
   logic                resetn;
   logic                tooth_in;
   logic                fire;
   logic                tpr_wr;
   tooth_program_t      tpr_wdata;
   logic [`RATE_W-1:0]  tick_rate_value;
   logic [`PRESC_W-1:0] time_base_prescaler;
   counter_status_t     status;
   logic [`ANGLE_W-1:0] angle_count;
   logic                tooth_event;
   logic                tick_pulse;
   logic                microcycle;
   logic                tpr_buffer_full;
   int                  err_count = 0;
   int                  total_checks = 0;
   int                  teeth = 0;
   angle_counter_tooth_logic u_dut (.sys_clk, .resetn, .tooth_in, .tpr_wr,
      .tpr_wdata, .tick_rate_value, .time_base_prescaler, .status,
      .angle_count, .tooth_event, .tick_pulse, .microcycle, .tpr_buffer_full);
   tooth_wheel_model u_wheel (.sys_clk, .fire, .tooth_in);
   // tooth events seen, physical and dummy alike
   always @(posedge sys_clk) if (tooth_event === 1'b1) teeth++;
   task automatic check(string name, logic [23:0] seen, logic [23:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic restart();
      resetn = 1'b0;
      repeat (12) @(posedge sys_clk);
      #1 resetn = 1'b1;
   endtask
   task automatic wr(logic [9:0] t, logic [7:0] m, logic l, logic i);
      @(posedge sys_clk);
      #1 tpr_wr = 1'b1;
      tpr_wdata = '{t, m, l, i};
      @(posedge sys_clk);
      #1 tpr_wr = 1'b0;
   endtask
   task automatic tooth();
      @(posedge sys_clk);
      #1 fire = 1'b1;
      @(posedge sys_clk);
      #1 fire = 1'b0;
   endtask
   task automatic wait_mode(counter_mode_t m, int n);
      int k;
      k = 0;
      while (status.mode !== m && k < n) begin
         @(posedge sys_clk);
         #1 k++;
      end
      check("mode", status.mode, m);
   endtask
   // bounded wait; the count must step through one before halting
   task automatic wait_halt();
      int   k;
      logic seen;
      k = 0;
      seen = 1'b0;
      while (status.mode !== mode_halt && k < 600) begin
         if (status.missing_tooth_count === 8'h01) seen = 1'b1;
         @(posedge sys_clk);
         #1 k++;
      end
      check("halt", status.mode, mode_halt);
      check("missing", status.missing_tooth_count, 8'h00);
      check("step", seen, 1'b1);
   endtask
   task automatic t_insert();
      int n;
      restart();
      check("status", status, '0);
      n = teeth;
      wr(10'h005, 8'h00, 1'b0, 1'b1);
      wait_mode(mode_normal, 8);
      repeat (4) @(posedge sys_clk);
      check("teeth", 24'(teeth - n), 24'h1);
   endtask
   // insert write racing a physical tooth, then a second write
   task automatic t_second();
      int n;
      restart();
      n = teeth;
      fork
         tooth();
         wr(10'h030, 8'h00, 1'b0, 1'b1);
      join
      // second write lands two microcycles later, with the physical tooth
      repeat (2) @(posedge sys_clk);
      wr(10'h040, 8'h00, 1'b1, 1'b0);
      repeat (12) @(posedge sys_clk);
      check("last", status.last, 1'b1);
      check("mode", status.mode, mode_normal);
      check("teeth", 24'(teeth - n), 24'h2);
   endtask
   task automatic t_early();
      restart();
      wr(10'h014, 8'h02, 1'b1, 1'b1);
      wait_mode(mode_normal, 8);
      repeat (6) @(posedge sys_clk);
      tooth();
      wait_mode(mode_high_rate, 12);
      check("missing", status.missing_tooth_count, 8'h00);
      check("last", status.last, 1'b0);
      wr(10'h001, 8'h02, 1'b0, 1'b0);
      wait_halt();
   endtask
   task automatic t_count();
      restart();
      wr(10'h002, 8'h03, 1'b0, 1'b0);
      repeat (8) @(posedge sys_clk);
      tooth();
      wait_mode(mode_normal, 12);
      wait_halt();
      // two ticks per tooth, one load plus three reloads
      check("angle", angle_count, 24'h000008);
   endtask
   task automatic summarize();
      if (err_count == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   initial begin
      resetn = 1'b0;
      fire = 1'b0;
      tpr_wr = 1'b0;
      tpr_wdata = '0;
      tick_rate_value = 15'h0004;
      time_base_prescaler = 6'h00;
      t_insert();
      t_second();
      t_early();
      t_count();
      summarize();
   end
   // the whole run needs a few hundred clocks
   initial begin
      #50000;
      err_count++;
      summarize();
   end
endmodule
bind angle_counter_tooth_logic angle_counter_tooth_logic_sva u_sva (
   .sys_clk, .resetn, .tpr_wr, .tpr_wdata, .status, .tooth_event,
   .microcycle, .tick_pulse, .tpr_buffer_full);
